// File: rtl/scp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module scp_pin_sync
    import scp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    output logic cs_n_s,
    output logic sck_rise,
    output logic sck_fall,
    output logic sdi_s
);

    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] meta_q;
    logic [PIN_COUNT-1:0] sync_q;
    logic sck_old_q;

    assign pins = {serial_data_in, serial_clk, chip_select_n};

    // Two-stage synchroniser per pin; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++)
        begin : g_sync
            always_ff @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    meta_q[i] <= PIN_RST[i];
                    sync_q[i] <= PIN_RST[i];
                end
                else
                begin
                    meta_q[i] <= pins[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    // Extra stage so edges are found on synchronised values only
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sck_old_q <= 1'b0;
        else
            sck_old_q <= sync_q[PIN_SCK];
    end

    assign cs_n_s = sync_q[PIN_CS];
    assign sdi_s = sync_q[PIN_SDI];
    assign sck_rise = sync_q[PIN_SCK] & ~sck_old_q;
    assign sck_fall = ~sync_q[PIN_SCK] & sck_old_q;

endmodule

`default_nettype wire

// File: rtl/scp_pkg.sv
package scp_pkg;

    // Core clock and power-on hold-off
    localparam int CLK_HZ = 100_000_000;
    localparam int POR_PULSE_MS = 100;
    localparam int POR_HOLD_CYCLES = POR_PULSE_MS * (CLK_HZ / 1000);
    localparam int POR_CNT_W = 24;

    // Frame geometry
    localparam int CMD_BITS = 16;
    localparam int CODE_BITS = 8;
    localparam int CNT_W = 5;
    localparam int STAT_BITS = 8;

    // Pin synchroniser lanes and their reset levels (select idles high)
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_COUNT = 3;
    localparam logic [2:0] PIN_RST = 3'h1;

    // Four-bit command codes
    localparam logic [3:0] CODE4_CFG = 4'h9;
    localparam logic [3:0] CODE4_FREQ = 4'hA;
    localparam logic [3:0] CODE4_WAKE = 4'hE;

    // Eight-bit command codes
    localparam logic [7:0] CODE_PWR = 8'hC0;
    localparam logic [7:0] CODE_LBD = 8'hC2;
    localparam logic [7:0] CODE_FIFO_WR = 8'hC6;
    localparam logic [7:0] CODE_RATE = 8'hC8;
    localparam logic [7:0] CODE_FIFO_SET = 8'hCE;
    localparam logic [7:0] CODE_EXT_FEAT = 8'hB8;
    localparam logic [7:0] CODE_STATUS = 8'hB0;

    // Field positions
    localparam int FE_BIT = 7;
    localparam int PLLBW_LSB = 0;

    // Frequency parameter legal range
    localparam logic [11:0] FREQ_MIN = 12'h060;
    localparam logic [11:0] FREQ_MAX = 12'hF3F;

    // Loop bandwidth encodings
    localparam logic [1:0] BW_15K = 2'h0;
    localparam logic [1:0] BW_30K = 2'h1;
    localparam logic [1:0] BW_60K = 2'h2;
    localparam logic [1:0] BW_120K = 2'h3;

    // Command register file carried as one bundle
    typedef struct packed {
        logic [11:0] cfg_word;
        logic [11:0] freq;
        logic [5:0] power;
        logic fifo_en;
        logic [5:0] fifo_level;
        logic [7:0] rate;
        logic [7:0] lowbat;
        logic [11:0] wakeup;
        logic [7:0] ext_feat;
    } scp_regs_t;

    // Values after power-on
    localparam scp_regs_t REGS_RST = '{
        cfg_word: 12'h082,
        freq: 12'hD57,
        power: 6'h02,
        fifo_en: 1'h0,
        fifo_level: 6'h00,
        rate: 8'h13,
        lowbat: 8'h13,
        wakeup: 12'h196,
        ext_feat: 8'h02
    };

    typedef enum logic [1:0] {
        ST_CMD,
        ST_FIFO,
        ST_STAT
    } scp_state_t;

endpackage

// File: rtl/scp_serial_command_port.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// (R01) Sample data on clock rise while selected
// (R02) Select high resets receiver to fresh frame
// (R03) Host sends whole bytes except FIFO data
// (R04) Leading code bits pick the command
// (R05) Words arrive most significant bit first
// (R06) Don't-care bits never change behaviour
// (R07) Power-on loads defaults into all registers
// (R08) Two-bit loop bandwidth select, default 10
// (R09) Bandwidth caps bit rate; host obeys
// (R10) Bandwidth lives in extended features register
// (R11) Status read command returns status bits
// (R12) Ignore commands during power-on pulse
// (R13) FIFO write pushes data bits when enabled
// (R14) Out-of-range frequency write is discarded
// (R15) Registers update only on complete frames
module scp_serial_command_port
    import scp_pkg::*;
#(
    parameter int POR_HOLD = POR_HOLD_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic [STAT_BITS-1:0] status_bits,
    output logic serial_data_out,
    output scp_regs_t regs,
    output logic [1:0] pll_bandwidth_sel,
    output logic fifo_enable,
    output logic fifo_push,
    output logic fifo_bit,
    output logic port_ready
);

    logic cs_n_s;
    logic sck_rise;
    logic sck_fall;
    logic sdi_s;

    logic [POR_CNT_W-1:0] por_cnt_q;
    logic [POR_CNT_W-1:0] por_cnt_d;
    logic por_done;

    scp_state_t st_q;
    scp_state_t st_d;
    logic [CMD_BITS-1:0] sh_q;
    logic [CMD_BITS-1:0] sh_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic armed_q;
    logic armed_d;
    scp_regs_t regs_q;
    scp_regs_t regs_d;
    logic push_q;
    logic push_d;
    logic bit_q;
    logic bit_d;
    logic [STAT_BITS-1:0] so_q;
    logic [STAT_BITS-1:0] so_d;
    logic sdo_q;
    logic sdo_d;

    scp_pin_sync u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .chip_select_n(chip_select_n),
        .serial_clk(serial_clk),
        .serial_data_in(serial_data_in),
        .cs_n_s(cs_n_s),
        .sck_rise(sck_rise),
        .sck_fall(sck_fall),
        .sdi_s(sdi_s)
    );

    // Power-on hold-off counter; saturates once the pulse is over
    assign por_done = (por_cnt_q == POR_CNT_W'(POR_HOLD));

    always_comb
    begin
        por_cnt_d = por_cnt_q;
        if (!por_done)
            por_cnt_d = por_cnt_q + 1'b1; // [R12]
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            por_cnt_q <= '0;
        else
            por_cnt_q <= por_cnt_d;
    end

    // Frame receiver, decoder and register file
    always_comb
    begin
        logic [CMD_BITS-1:0] word;
        word = {sh_q[CMD_BITS-2:0], sdi_s}; // [R05]
        st_d = st_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        armed_d = armed_q;
        regs_d = regs_q;
        push_d = 1'b0;
        bit_d = bit_q;
        so_d = so_q;
        sdo_d = sdo_q;
        if (cs_n_s)
        begin
            // Deselect drops any partial frame, so no register moves [R02] [R15]
            st_d = ST_CMD;
            cnt_d = '0;
            sdo_d = 1'b0;
            // A frame counts only if it began after the hold-off ended [R12]
            armed_d = por_done;
        end
        else
        begin
            if (armed_q && sck_rise) // [R01]
            begin
                case (st_q)
                    ST_CMD:
                    begin
                        sh_d = word;
                        cnt_d = cnt_q + 1'b1;
                        if (cnt_q == CNT_W'(CODE_BITS - 1))
                        begin
                            // Eight-bit codes that switch the frame's meaning [R04]
                            if (word[CODE_BITS-1:0] == CODE_FIFO_WR)
                                st_d = ST_FIFO;
                            else if (word[CODE_BITS-1:0] == CODE_STATUS)
                            begin
                                st_d = ST_STAT;
                                so_d = status_bits; // [R11]
                            end
                        end
                        if (cnt_q == CNT_W'(CMD_BITS - 1))
                        begin
                            // Full word in hand: commit; only defined fields stored [R15] [R06]
                            cnt_d = '0;
                            if (word[15:12] == CODE4_CFG)
                                regs_d.cfg_word = word[11:0];
                            else if (word[15:12] == CODE4_FREQ)
                            begin
                                if (word[11:0] >= FREQ_MIN && word[11:0] <= FREQ_MAX)
                                    regs_d.freq = word[11:0]; // [R14]
                            end
                            else if (word[15:12] == CODE4_WAKE)
                                regs_d.wakeup = word[11:0];
                            else
                            begin
                                case (word[15:8]) // [R04]
                                    CODE_PWR: regs_d.power = word[5:0];
                                    CODE_LBD: regs_d.lowbat = word[7:0];
                                    CODE_RATE: regs_d.rate = word[7:0];
                                    CODE_FIFO_SET:
                                    begin
                                        regs_d.fifo_en = word[FE_BIT];
                                        regs_d.fifo_level = word[5:0];
                                    end
                                    CODE_EXT_FEAT: regs_d.ext_feat = word[7:0]; // [R10]
                                    default: regs_d = regs_q;
                                endcase
                            end
                        end
                    end
                    ST_FIFO:
                    begin
                        // Any number of data bits; each is pushed as it lands while fifo_en is set [R13] [R03]
                        push_d = regs_q.fifo_en;
                        bit_d = sdi_s;
                    end
                    ST_STAT:
                        st_d = ST_STAT;
                    default:
                        st_d = ST_CMD;
                endcase
            end
            // Status shifts out on falling edges so the host samples on the rise
            if (st_q == ST_STAT && sck_fall)
            begin
                sdo_d = so_q[STAT_BITS-1]; // [R11]
                so_d = {so_q[STAT_BITS-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= ST_CMD;
            sh_q <= '0;
            cnt_q <= '0;
            armed_q <= 1'b0;
            regs_q <= REGS_RST; // [R07]
            push_q <= 1'b0;
            bit_q <= 1'b0;
            so_q <= '0;
            sdo_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            armed_q <= armed_d;
            regs_q <= regs_d;
            push_q <= push_d;
            bit_q <= bit_d;
            so_q <= so_d;
            sdo_q <= sdo_d;
        end
    end

    // Outputs straight from flops, except port_ready, which is decoded from the hold-off counter
    assign regs = regs_q;
    // The host must keep its bit rate within what this bandwidth supports
    assign pll_bandwidth_sel = regs_q.ext_feat[PLLBW_LSB +: 2]; // [R08] [R10] [R09]
    assign fifo_enable = regs_q.fifo_en;
    assign fifo_push = push_q;
    assign fifo_bit = bit_q;
    assign serial_data_out = sdo_q;
    assign port_ready = por_done;

endmodule

`default_nettype wire

// File: verif/scp_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none

module scp_checker_sva
    import scp_pkg::*;
#(
    parameter int POR_HOLD = POR_HOLD_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic chip_select_n,
    input wire logic serial_data_out,
    input wire scp_regs_t regs,
    input wire logic [1:0] pll_bandwidth_sel,
    input wire logic fifo_enable,
    input wire logic fifo_push,
    input wire logic port_ready
);
    int cnt_q;
    int cnt_d;

    // Cycles since reset release; saturates so a long run never wraps
    always_comb
    begin
        cnt_d = (cnt_q < POR_HOLD + 8) ? cnt_q + 1 : cnt_q;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 0;
        else
            cnt_q <= cnt_d;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Select held high long enough to pass the pin synchroniser
    sequence s_desel;
        chip_select_n [*6];
    endsequence

    sequence s_push_end;
        ##1 !fifo_push;
    endsequence

    // Slack of two cycles either side allows for the counter phase
    chk_ready_early: assert property (cnt_q < POR_HOLD - 2 |-> !port_ready)
        else $error("ready before hold-off");
    chk_ready_late: assert property (cnt_q > POR_HOLD + 2 |-> port_ready)
        else $error("ready missing after hold-off");
    chk_early_regs: assert property (!port_ready |=> $stable(regs))
        else $error("register write during hold-off");
    chk_regs_sel: assert property (!$stable(regs) |-> !chip_select_n)
        else $error("register write while deselected");
    chk_freq_range: assert property (regs.freq >= FREQ_MIN && regs.freq <= FREQ_MAX)
        else $error("frequency outside range");
    chk_bw_field: assert property (pll_bandwidth_sel == regs.ext_feat[1:0])
        else $error("bandwidth not from feature register");
    chk_fe_field: assert property (fifo_enable == regs.fifo_en)
        else $error("fifo enable mismatch");
    chk_push_gate: assert property (fifo_push |-> fifo_enable)
        else $error("push while fifo disabled");
    chk_push_one: assert property (fifo_push |-> s_push_end)
        else $error("push longer than a cycle");
    chk_sdo_idle: assert property (s_desel |-> !serial_data_out)
        else $error("data out while deselected");
endmodule

`default_nettype wire

// File: verif/scp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module scp_host_model
(
    output logic chip_select_n,
    output logic serial_clk,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    logic [15:0] rd = 16'h0000;

    // Idle: deselected, clock parked low between frames
    initial
    begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
    end

    // Data moves 5 ns after the fall, read back just before the next fall
    // Pins move by non-blocking assignment so a pin edge on a clock edge never races the synchroniser
    task bit1(input logic b);
        #5 serial_data_in <= b;
        #35 serial_clk <= 1'b1;
        #38 rd = {rd[14:0], serial_data_out};
        #2 serial_clk <= 1'b0;
    endtask

    // Whole bytes only, most significant first
    task byte8(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            bit1(b[i]);
    endtask

    task word16(input logic [15:0] w);
        byte8(w[15:8]);
        byte8(w[7:0]);
    endtask

    task sel_low;
        chip_select_n <= 1'b0;
        #20;
    endtask

    // Released data line shows the inverse so a stale bit is never trusted
    task sel_high;
        #40 chip_select_n <= 1'b1;
        serial_data_in <= ~serial_data_in;
        #80;
    endtask
endmodule

`default_nettype wire

// File: verif/tb_serial_command_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_serial_command_port
    import scp_pkg::*;
;
    localparam int POR_HOLD = 400;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [STAT_BITS-1:0] status_bits = 8'hA5;
    logic chip_select_n, serial_clk, serial_data_in, serial_data_out;
    logic fifo_enable, fifo_push, fifo_bit, port_ready;
    logic [1:0] pll_bandwidth_sel;
    scp_regs_t regs;
    int fails = 0;
    int n_tests = 0;
    int npush = 0;
    int cyc = 0;
    logic [7:0] fbits = 8'h00;
    logic [4:0] pat = 5'h16;
    // Command word in the upper half, field expected after it below
    // Fixed bits 7:6 of the power word are set once to show they are ignored
    logic [31:0] rows [15] = '{32'h9ABC0ABC, 32'hA05F0D57, 32'hA0600060, 32'hAF400060, 32'hAF3F0F3F,
        32'hC03F003F, 32'hC0C10001, 32'hCE850085, 32'hC8A500A5, 32'hC2F100F1, 32'hE5A505A5,
        32'hB8000000, 32'hB8010001, 32'hB8020002, 32'hB8030003};

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    scp_serial_command_port #(.POR_HOLD(POR_HOLD)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_data_in(serial_data_in),
        .status_bits(status_bits), .serial_data_out(serial_data_out), .regs(regs),
        .pll_bandwidth_sel(pll_bandwidth_sel), .fifo_enable(fifo_enable), .fifo_push(fifo_push),
        .fifo_bit(fifo_bit), .port_ready(port_ready));

    scp_host_model host (.chip_select_n(chip_select_n), .serial_clk(serial_clk),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

    // Push log and hang guard
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (fifo_push === 1'b1)
        begin
            npush <= npush + 1;
            fbits <= {fbits[6:0], fifo_bit};
        end
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end

    task check(input logic [83:0] seen, input logic [83:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Field that a command word targets
    function automatic logic [15:0] fld(input logic [15:0] w);
        case (w[15:12])
            CODE4_CFG: fld = {4'h0, regs.cfg_word};
            CODE4_FREQ: fld = {4'h0, regs.freq};
            CODE4_WAKE: fld = {4'h0, regs.wakeup};
            default:
                case (w[15:8])
                    CODE_PWR: fld = {10'h000, regs.power};
                    CODE_FIFO_SET: fld = {8'h00, regs.fifo_en, 1'b0, regs.fifo_level};
                    CODE_RATE: fld = {8'h00, regs.rate};
                    CODE_LBD: fld = {8'h00, regs.lowbat};
                    default: fld = {8'h00, regs.ext_feat};
                endcase
        endcase
    endfunction

    task frame(input logic [15:0] w);
        host.sel_low();
        host.word16(w);
        host.sel_high();
    endtask

    initial
    begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        #1 check(regs, REGS_RST);
        frame(16'h9123);
        check(port_ready, 1'b0);
        check(regs, REGS_RST);
        for (int i = 0; i < 1000 && port_ready !== 1'b1; i++)
            @(posedge core_clk);
        check(port_ready, 1'b1);
        foreach (rows[i])
        begin
            frame(rows[i][31:16]);
            check(fld(rows[i][31:16]), rows[i][15:0]);
            if (rows[i][31:24] == CODE_EXT_FEAT)
                check(pll_bandwidth_sel, rows[i][1:0]);
        end
        // Two commands in one select period, then halves split by a deselect
        host.sel_low();
        host.word16(16'h9111);
        host.word16(16'hA222);
        host.sel_high();
        check({regs.cfg_word, regs.freq}, 24'h111222);
        host.sel_low();
        host.byte8(8'h93);
        host.sel_high();
        frame(16'h33C6);
        check(regs.cfg_word, 12'h111);
        // Odd-length FIFO data while enabled, then while disabled
        host.sel_low();
        host.byte8(CODE_FIFO_WR);
        for (int i = 4; i >= 0; i--)
            host.bit1(pat[i]);
        host.sel_high();
        check(npush, 5);
        check(fbits[4:0], pat);
        frame(16'hCE00);
        check(fifo_enable, 1'b0);
        host.sel_low();
        host.byte8(CODE_FIFO_WR);
        host.bit1(1'b1);
        host.sel_high();
        check(npush, 5);
        frame({CODE_STATUS, 8'h00});
        check(host.rd[7:0], status_bits);
        // Second reset in mid-run
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(regs, REGS_RST);
        check(pll_bandwidth_sel, BW_60K);
        // Release again: a frame inside the new hold-off must be dropped
        rst_b <= 1'b1;
        frame(16'h9456);
        check(port_ready, 1'b0);
        check(regs, REGS_RST);
        print_verdict();
    end
endmodule

bind scp_serial_command_port scp_checker_sva #(.POR_HOLD(POR_HOLD)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .chip_select_n(chip_select_n), .serial_data_out(serial_data_out), .regs(regs),
    .pll_bandwidth_sel(pll_bandwidth_sel), .fifo_enable(fifo_enable), .fifo_push(fifo_push),
    .port_ready(port_ready));

`default_nettype wire
